/* File: handset_power_up_sequencer_test.sv */
// testbench: both ends joined, sequencing and serial commands checked
`timescale 1ns/1ps
`default_nettype none
module handset_power_up_sequencer_test;
  import hpus_pkg::*;
  localparam int unsigned RCNT = 100;
  logic        i_mclk, i_rst, uv, refr, bgood, lgood, otemp, on_req, ka, wr, rd;
  logic [7:0]  addr, wdata, rdata, st;
  logic [5:0]  en;
  logic [19:0] cd;
  int          err_total, n_tests;
  hpus_link_if link ();
  hpus_host u_hpus_host (.i_mclk(i_mclk), .i_rst(i_rst), .link(link), .i_on_request(on_req),
    .i_keep_alive(ka), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
  hpus_device #(.RESET_CNT(RCNT), .STARTUP_CNT(RCNT)) u_hpus_device (.i_mclk(i_mclk), .i_rst(i_rst),
    .link(link), .i_undervoltage_rising_threshold(uv), .i_ref_ready(refr), .i_buck_good(bgood),
    .i_ldo_b_good(lgood), .i_over_temp(otemp), .o_ref_en(en[5]), .o_buck_output_en(en[4]),
    .o_ldo_a_output_en(en[3]), .o_ldo_b_output_en(en[2]), .o_charge_pump_output_en(en[1]),
    .o_ldo_e_output_en(en[0]), .o_buck_code(cd[19:16]), .o_ldo_a_voltage_code(cd[15:12]),
    .o_ldo_b_code(cd[11:8]), .o_ldo_c_freq(cd[7:4]), .o_ldo_e_code(cd[3:0]));
  hpus_link_props #(.RESET_CNT(RCNT)) u_hpus_link_props (.i_mclk(i_mclk), .i_rst(i_rst),
    .scl(link.scl), .sda(link.sda), .sda_dev_oe(link.sda_dev_oe), .sda_host_oe(link.sda_host_oe),
    .on_n(link.on_n), .keep_alive(link.keep_alive), .reset_n(link.reset_n),
    .on_request_status(link.on_request_status));
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : step
  task automatic chk(input logic [25:0] s, input logic [25:0] e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic wr_bus(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
  endtask : wr_bus
  // read data is registered on the strobe and holds until the next read
  task automatic rd_bus(input logic [7:0] a);
    @(posedge i_mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge i_mclk);
    rd <= 1'b0;
    #1;
    st = rdata;
  endtask : rd_bus
  // bounded poll of busy; a hang ends the run
  task automatic send(input logic [7:0] b);
    int i;
    wr_bus(8'h00, b);
    st = 8'h01;
    for (i = 0; i < 20000 && st[0] !== 1'b0; i++) rd_bus(8'h00);
    if (st[0] !== 1'b0) begin
      err_total++;
      $display("MISMATCH %0t frame never finished", $time);
      stop_test();
    end else begin
      chk(st[1], 1'b0);
      step(10);
    end
  endtask : send
  task automatic power_up();
    on_req <= 1'b1;
    step(20);
    on_req <= 1'b0;
    step(300);
  endtask : power_up
  initial begin
    {uv, refr, bgood, lgood, otemp, on_req, ka, wr, rd} = '0;
    addr = 8'h00;
    wdata = 8'h00;
    err_total = 0;
    n_tests = 0;
    i_rst = 1'b1;
    step(3);
    i_rst <= 1'b0;
    step(2);
    chk(cd, 20'hF4FFF);
    chk(en, 6'b000000);
    rd_bus(8'h00);
    chk(st[3:0], 4'b1000);
    wr_bus(8'h10, 8'hAA);
    step(2);
    rd_bus(8'h00);
    chk(st[0], 1'b0);
    $display("test defaults done");
    refr <= 1'b1;
    on_req <= 1'b1;
    step(20);
    chk(en, 6'b100000);
    rd_bus(8'h00);
    chk(st[3], 1'b0);
    uv <= 1'b1;
    step(20);
    chk(en, 6'b110000);
    bgood <= 1'b1;
    step(20);
    chk(en, 6'b110110);
    lgood <= 1'b1;
    step(20);
    chk(en, 6'b111111);
    on_req <= 1'b0;
    step(20);
    rd_bus(8'h00);
    chk(st[3:2], 2'b10);
    step(100);
    rd_bus(8'h00);
    chk(st[2], 1'b1);
    chk(en, 6'b111111);
    step(120);
    chk(en, 6'b000000);
    $display("test sequence done");
    ka <= 1'b1;
    power_up();
    chk(en, 6'b111111);
    send(8'h0A);
    chk(cd[19:16], 4'hA);
    send(8'h13);
    chk(cd[15:12], 4'h3);
    send(8'h35);
    chk(cd[7:4], 4'h5);
    send(8'h56);
    chk(en, 6'b110110);
    send(8'h60);
    chk(en, 6'b100110);
    send(8'h7F);
    chk({cd, en}, {20'hA3F5F, 6'b100110});
    ka <= 1'b0;
    step(20);
    chk(en, 6'b000000);
    $display("test commands done");
    ka <= 1'b1;
    power_up();
    chk(en[5], 1'b1);
    otemp <= 1'b1;
    step(20);
    chk(en, 6'b000000);
    otemp <= 1'b0;
    ka <= 1'b0;
    $display("test thermal done");
    stop_test();
  end
endmodule : handset_power_up_sequencer_test
`default_nettype wire

/* File: hpus_byte_rx.sv */
// receive-byte slave: address match, acknowledge, one data byte out
`timescale 1ns/1ps
`default_nettype none
module hpus_byte_rx
  import hpus_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda_oe,
  output logic            o_byte_valid,
  output logic [7:0]      o_byte
);
  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic       scl_reg;
  logic       sda_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic       phase_reg;
  logic       active_reg;
  // a level counts once stages two and three agree
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_reg      <= 1'b1;
      sda_reg      <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], i_scl};
      sda_sync_reg <= {sda_sync_reg[1:0], i_sda};
      if (scl_sync_reg[1] == scl_sync_reg[2])
        scl_reg <= scl_sync_reg[2];
      if (sda_sync_reg[1] == sda_sync_reg[2])
        sda_reg <= sda_sync_reg[2];
    end
  end
  wire scl_rise = (scl_sync_reg[1] == scl_sync_reg[2]) & scl_sync_reg[2] & ~scl_reg;
  wire scl_fall = (scl_sync_reg[1] == scl_sync_reg[2]) & ~scl_sync_reg[2] & scl_reg;
  wire sda_new  = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_reg;
  wire scl_new  = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_reg;
  // clock must stay high across the data edge, else a data change on a falling clock looks like start
  wire start_c  = scl_reg & scl_new & sda_reg & ~sda_new;
  wire stop_c   = scl_reg & scl_new & ~sda_reg & sda_new;
  // slave only: drives data low for acknowledge, never the clock
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      phase_reg    <= 1'b0;
      active_reg   <= 1'b0;
      o_sda_oe     <= 1'b0;
      o_byte_valid <= 1'b0;
      o_byte       <= 8'h00;
    end else begin
      o_byte_valid <= 1'b0;
      if (start_c) begin
        active_reg  <= 1'b1;
        phase_reg   <= 1'b0;
        bit_cnt_reg <= 4'h0;
        o_sda_oe    <= 1'b0;
      end else if (stop_c) begin
        active_reg <= 1'b0;
        o_sda_oe   <= 1'b0;
      end else if (active_reg && scl_rise && bit_cnt_reg < 4'h8) begin
        shift_reg   <= {shift_reg[6:0], sda_reg};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end else if (active_reg && scl_fall) begin
        if (bit_cnt_reg == 4'h8 && !o_sda_oe) begin
          // acknowledge only our address with write direction
          if (!phase_reg && shift_reg == {SLAVE_ADDR, 1'b0}) begin
            o_sda_oe  <= 1'b1;
            phase_reg <= 1'b1;
          end else if (phase_reg) begin
            o_sda_oe     <= 1'b1;
            o_byte       <= shift_reg;
            o_byte_valid <= 1'b1;
          end else begin
            active_reg <= 1'b0;
          end
        end else if (o_sda_oe) begin
          o_sda_oe    <= 1'b0;
          bit_cnt_reg <= 4'h0;
        end
      end
    end
  end
endmodule : hpus_byte_rx
`default_nettype wire

/* File: hpus_device.sv */
// device end: power-up sequencer, timers and serial control registers
`timescale 1ns/1ps
`default_nettype none
module hpus_device
  import hpus_pkg::*;
#(
  parameter int unsigned RESET_CNT   = RESET_CYCLES,
  parameter int unsigned STARTUP_CNT = STARTUP_CYCLES
) (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  hpus_link_if.device     link,
  input  wire logic       i_undervoltage_rising_threshold,
  input  wire logic       i_ref_ready,
  input  wire logic       i_buck_good,
  input  wire logic       i_ldo_b_good,
  input  wire logic       i_over_temp,
  output logic            o_ref_en,
  output logic            o_buck_output_en,
  output logic            o_ldo_a_output_en,
  output logic            o_ldo_b_output_en,
  output logic            o_charge_pump_output_en,
  output logic            o_ldo_e_output_en,
  output logic [3:0]      o_buck_code,
  output logic [3:0]      o_ldo_a_voltage_code,
  output logic [3:0]      o_ldo_b_code,
  output logic [3:0]      o_ldo_c_freq,
  output logic [3:0]      o_ldo_e_code
);
  import hpus_pkg::*;
  hpus_state_type state_reg;
  logic [31:0]    timer_reg;
  logic [2:0]     on_sync_reg;
  logic [2:0]     ka_sync_reg;
  logic           on_n_reg;
  logic           ka_reg;
  logic [3:0]     regulator_enable_bits_reg;
  logic           buck_on_reg;
  logic           off_cmd_reg;
  logic           byte_valid;
  logic [7:0]     cmd_byte;
  logic           reset_n_reg;
  logic           status_reg;
  hpus_byte_rx u_rx (
    .i_mclk       (i_mclk),
    .i_rst        (i_rst),
    .i_scl        (link.scl),
    .i_sda        (link.sda),
    .o_sda_oe     (link.sda_dev_oe),
    .o_byte_valid (byte_valid),
    .o_byte       (cmd_byte)
  );
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      on_sync_reg <= 3'h7;
      ka_sync_reg <= 3'h0;
      on_n_reg    <= 1'b1;
      ka_reg      <= 1'b0;
    end else begin
      on_sync_reg <= {on_sync_reg[1:0], link.on_n};
      ka_sync_reg <= {ka_sync_reg[1:0], link.keep_alive};
      if (on_sync_reg[1] == on_sync_reg[2])
        on_n_reg <= on_sync_reg[2];
      if (ka_sync_reg[1] == ka_sync_reg[2])
        ka_reg <= ka_sync_reg[2];
    end
  end
  wire [3:0] cmd_addr = cmd_byte[7:4];
  wire [3:0] cmd_data = cmd_byte[3:0];
  wire       powered  = (state_reg == ST_RESET) || (state_reg == ST_STARTUP) || (state_reg == ST_ON);
  wire       shutdown = i_over_temp || off_cmd_reg;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_buck_code          <= CODE_RESET;
      o_ldo_a_voltage_code <= LDOA_CODE_RESET;
      o_ldo_b_code         <= CODE_RESET;
      o_ldo_c_freq         <= CODE_RESET;
      o_ldo_e_code         <= CODE_RESET;
      regulator_enable_bits_reg <= ENABLES_RESET;
      buck_on_reg               <= 1'b1;
      off_cmd_reg               <= 1'b0;
    end else begin
      off_cmd_reg <= 1'b0;
      if (byte_valid) begin
        case (cmd_addr)
          ADDR_BUCK_CODE: o_buck_code          <= cmd_data;
          ADDR_LDOA_CODE: o_ldo_a_voltage_code <= cmd_data;
          ADDR_LDOB_CODE: o_ldo_b_code         <= cmd_data;
          ADDR_LDOC_FREQ: o_ldo_c_freq         <= cmd_data;
          ADDR_LDOE_CODE: o_ldo_e_code         <= cmd_data;
          ADDR_ENABLES:   regulator_enable_bits_reg <= cmd_data;
          ADDR_BUCK_ON: begin
            buck_on_reg <= cmd_data[BUCK_ON_BIT];
            off_cmd_reg <= cmd_data[OFF_BIT] & powered;
          end
          default: ;
        endcase
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_reg <= ST_OFF;
      timer_reg <= 32'h0;
    end else if (state_reg != ST_OFF && shutdown) begin
      state_reg <= ST_OFF;
    end else begin
      timer_reg <= timer_reg + 32'h1;
      case (state_reg)
        ST_OFF: begin
          // reference first; a hot die would only glitch the reference
          if (!on_n_reg && !i_over_temp) begin
            state_reg <= ST_REF;
          end
        end
        ST_REF: begin
          if (i_ref_ready && i_undervoltage_rising_threshold) begin
            state_reg <= ST_BUCK;
          end
        end
        ST_BUCK: begin
          if (i_buck_good) begin
            state_reg <= ST_LDO_B;
          end
        end
        ST_LDO_B: begin
          if (i_ldo_b_good) begin
            state_reg <= ST_RESET;
            timer_reg <= 32'h0;
          end
        end
        ST_RESET: begin
          if (timer_reg >= RESET_CNT - 1) begin
            state_reg <= ST_STARTUP;
            timer_reg <= 32'h0;
          end
        end
        ST_STARTUP: begin
          // keep-alive missing at timeout, powered off
          if (ka_reg) begin
            state_reg <= ST_ON;
          end else if (timer_reg >= STARTUP_CNT - 1) begin
            state_reg <= ST_OFF;
          end
        end
        ST_ON: begin
          if (!ka_reg) begin
            state_reg <= ST_OFF;
          end
        end
        default: state_reg <= ST_OFF;
      endcase
    end
  end
  // outputs registered from state and enables
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ref_en                <= 1'b0;
      o_buck_output_en        <= 1'b0;
      o_ldo_b_output_en       <= 1'b0;
      o_charge_pump_output_en <= 1'b0;
      o_ldo_a_output_en       <= 1'b0;
      o_ldo_e_output_en       <= 1'b0;
      reset_n_reg             <= 1'b0;
      status_reg              <= 1'b1;
    end else begin
      o_ref_en                <= state_reg != ST_OFF;
      o_buck_output_en        <= buck_on_reg && state_reg != ST_OFF && state_reg != ST_REF;
      o_ldo_b_output_en       <= regulator_enable_bits_reg[EN_LDO_B] && (state_reg == ST_LDO_B || powered);
      o_charge_pump_output_en <= regulator_enable_bits_reg[EN_PUMP] && (state_reg == ST_LDO_B || powered);
      o_ldo_a_output_en       <= regulator_enable_bits_reg[EN_LDO_A] && powered;
      o_ldo_e_output_en       <= regulator_enable_bits_reg[EN_LDO_E] && powered;
      // reset released only after reset period
      reset_n_reg             <= (state_reg == ST_STARTUP) || (state_reg == ST_ON);
      status_reg              <= on_n_reg;
    end
  end
  assign link.reset_n           = reset_n_reg;
  assign link.on_request_status = status_reg;
endmodule : hpus_device
`default_nettype wire

/* File: hpus_host.sv */
// controller end: button, keep-alive and receive-byte bus master
`timescale 1ns/1ps
`default_nettype none
module hpus_host
  import hpus_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  hpus_link_if.host       link,
  input  wire logic       i_on_request,
  input  wire logic       i_keep_alive,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata
);
  import hpus_pkg::*;
  logic [7:0]  div_reg;
  logic [4:0]  step_reg;
  logic [17:0] frame_reg;
  logic        busy_reg;
  logic        scl_reg;
  logic        sda_oe_reg;
  logic        nack_reg;
  logic        on_n_reg;
  logic        ka_reg;
  localparam logic [4:0] STEP_ACK_ADDR = 5'h08;
  localparam logic [4:0] STEP_ACK_DATA = 5'h11;
  localparam logic [4:0] STEP_STOP_LOW = 5'h12;
  localparam logic [4:0] STEP_STOP     = 5'h13;
  localparam logic [4:0] STEP_LAST_BIT = 5'h11;
  wire tick     = (div_reg == SCL_DIV);
  wire start_go = !busy_reg && i_wr && (i_addr == 8'h00);
  // restart the divider at start so the start condition gets a full half period
  always_ff @(posedge i_mclk) begin
    if (i_rst || start_go) div_reg <= 8'h00;
    else div_reg <= tick ? 8'h00 : div_reg + 8'h01;
  end
  // keep-alive and button registered once; button inverted to active-low on_n
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      on_n_reg <= 1'b1;
      ka_reg   <= 1'b0;
    end else begin
      on_n_reg <= ~i_on_request;
      ka_reg   <= i_keep_alive;
    end
  end
  // address fixed by SLAVE_ADDR, one data byte from software
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      busy_reg   <= 1'b0;
      step_reg   <= 5'h00;
      frame_reg  <= 18'h3FFFF;
      scl_reg    <= 1'b1;
      sda_oe_reg <= 1'b0;
      nack_reg   <= 1'b0;
    end else if (!busy_reg) begin
      if (start_go) begin
        busy_reg   <= 1'b1;
        step_reg   <= 5'h00;
        frame_reg  <= {SLAVE_ADDR, 1'b0, 1'b1, i_wdata, 1'b1};
        nack_reg   <= 1'b0;
        // start: data falls while the clock stands high
        sda_oe_reg <= 1'b1;
      end
    end else if (tick) begin
      if (scl_reg && step_reg == STEP_STOP) begin
        // stop: data rises while the clock stands high
        sda_oe_reg <= 1'b0;
        busy_reg   <= 1'b0;
      end else if (scl_reg) begin
        // data only changes with the clock low
        scl_reg <= 1'b0;
        if (step_reg == STEP_STOP_LOW) sda_oe_reg <= 1'b1;
        else sda_oe_reg <= ~frame_reg[STEP_LAST_BIT - step_reg];
      end else begin
        scl_reg  <= 1'b1;
        step_reg <= step_reg + 5'h01;
        if ((step_reg == STEP_ACK_ADDR || step_reg == STEP_ACK_DATA) && link.sda)
          nack_reg <= 1'b1;
      end
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst) o_rdata <= 8'h00;
    else if (i_rd) o_rdata <= {4'h0, link.on_request_status, link.reset_n, nack_reg, busy_reg};
  end
  assign link.scl         = scl_reg;
  assign link.sda_host_oe = sda_oe_reg;
  assign link.on_n        = on_n_reg;
  assign link.keep_alive  = ka_reg;
endmodule : hpus_host
`default_nettype wire

/* File: hpus_link_if.sv */
// interface: serial two-wire bus plus power-control pins between controller and device
`timescale 1ns/1ps
`default_nettype none
interface hpus_link_if;
  logic scl;
  logic sda_dev_oe;
  logic sda_host_oe;
  logic sda;
  logic on_n;
  logic keep_alive;
  logic reset_n;
  logic on_request_status;
  assign sda = ~(sda_dev_oe | sda_host_oe);
  modport device (input scl, input sda, output sda_dev_oe, input on_n, input keep_alive,
                  output reset_n, output on_request_status);
  modport host (output scl, input sda, output sda_host_oe, output on_n, output keep_alive,
                input reset_n, input on_request_status);
endinterface : hpus_link_if
`default_nettype wire

/* File: hpus_link_props.sv */
// checker: assertions on the serial link and power-control pins
`timescale 1ns/1ps
`default_nettype none
module hpus_link_props #(
  parameter int unsigned RESET_CNT = 100
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe,
  input wire logic sda_host_oe,
  input wire logic on_n,
  input wire logic keep_alive,
  input wire logic reset_n,
  input wire logic on_request_status
);
  localparam int ACK_MAX = 600;
  logic [15:0] low_cnt;
  logic [15:0] oe_cnt;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  // saturating so a long off period cannot wrap into a short count
  always_ff @(posedge i_mclk) begin
    if (i_rst || reset_n) low_cnt <= 16'h0000;
    else if (low_cnt != 16'hFFFF) low_cnt <= low_cnt + 16'h0001;
  end
  always_ff @(posedge i_mclk) begin
    if (i_rst || !sda_dev_oe) oe_cnt <= 16'h0000;
    else if (oe_cnt != 16'hFFFF) oe_cnt <= oe_cnt + 16'h0001;
  end
  sequence s_ack_start;
    $rose(sda_dev_oe) ##0 !scl;
  endsequence
  sequence s_ack_clock;
    sda_dev_oe ##0 $rose(scl);
  endsequence
  AST_STATUS_FOLLOW: assert property ($changed(on_n) |-> ##[1:6] (on_request_status == on_n))
    else $error("status did not follow button");
  AST_STATUS_CAUSE: assert property ($changed(on_request_status) |-> (on_request_status == on_n))
    else $error("status moved without button");
  AST_ACK_SCL_LOW: assert property ($rose(sda_dev_oe) |-> !scl)
    else $error("device drove data while clock high");
  AST_ACK_RELEASE: assert property (s_ack_clock |-> ##[1:300] !sda_dev_oe)
    else $error("device held data after ack clock");
  AST_ACK_NO_FIGHT: assert property (s_ack_start |-> !sda_host_oe)
    else $error("both ends drove data");
  AST_ACK_LEN: assert property (oe_cnt <= ACK_MAX)
    else $error("device ack too long");
  AST_RESET_HOLD: assert property ($rose(reset_n) |-> $past(low_cnt) >= RESET_CNT)
    else $error("reset released early");
  AST_SCL_HALF: assert property ($changed(scl) |=> $stable(scl) [*8])
    else $error("clock half period too short");
  AST_SDA_STEADY: assert property ((scl && $past(scl)) |-> $stable(sda_dev_oe))
    else $error("device changed data while clock high");
endmodule : hpus_link_props
`default_nettype wire

/* File: hpus_pkg.sv */
// package: constants, control byte layout, reset defaults and timing for the power-up sequencer
package hpus_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned RESET_TIME_MS   = 75;
  localparam int unsigned STARTUP_TIME_MS = 50;
  localparam int unsigned RESET_CYCLES    = (RESET_TIME_MS * (CLK_HZ / 1000));
  localparam int unsigned STARTUP_CYCLES  = (STARTUP_TIME_MS * (CLK_HZ / 1000));
  localparam logic [6:0] SLAVE_ADDR      = 7'h4F;
  localparam logic [3:0] ADDR_BUCK_CODE  = 4'h0;
  localparam logic [3:0] ADDR_LDOA_CODE  = 4'h1;
  localparam logic [3:0] ADDR_LDOB_CODE  = 4'h2;
  localparam logic [3:0] ADDR_LDOC_FREQ  = 4'h3;
  localparam logic [3:0] ADDR_LDOE_CODE  = 4'h4;
  localparam logic [3:0] ADDR_ENABLES    = 4'h5;
  localparam logic [3:0] ADDR_BUCK_ON    = 4'h6;
  localparam logic [3:0] CODE_RESET      = 4'hF;
  localparam logic [3:0] LDOA_CODE_RESET = 4'h4;
  localparam logic [3:0] ENABLES_RESET   = 4'hF;
  localparam int unsigned EN_LDO_A = 0;
  localparam int unsigned EN_LDO_B = 1;
  localparam int unsigned EN_PUMP  = 2;
  localparam int unsigned EN_LDO_E = 3;
  localparam int unsigned BUCK_ON_BIT = 0;
  localparam int unsigned OFF_BIT     = 1;
  localparam logic [7:0] SCL_DIV     = 8'hF9;
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_REF     = 3'b001,
    ST_BUCK    = 3'b011,
    ST_LDO_B   = 3'b010,
    ST_RESET   = 3'b110,
    ST_STARTUP = 3'b111,
    ST_ON      = 3'b101
  } hpus_state_type;
endpackage : hpus_pkg
